// [pcr_phy_control.sv]
// PHY control register with pause resolution, self-test control and indicators
// Summary of operation
// - Bit 15 enables auto crossover; strap default; read/write.
// - Bit 14 forces pairs crossed; resets to 0.
// - Read-only bit 13 is resolved pause receive, only for full duplex.
// - Read-only bit 12 is resolved pause transmit, only for full duplex.
// - Writing 1 to bit 11 injects one error, then clears itself.
// - Read-only bit 9 is pass flag; fail latches until test stopped.
// - Bit 8 starts self test when 1 and stops it when 0.
// - Bit 7 bypasses indicator stretching, showing raw state.
// - Bit 5 high: link on when good, speed on at 100 Mb/s.
// - Bit 5 low: link on when good and blinks on activity.
// - Bits 4:0 hold port address; strap loaded, read/write.
// - Companion 8-bit error counter clears on restart and saturates.
`timescale 1ns/1ps
module pcr_phy_control #(
    parameter int P_STRETCH_CYCLES = pcr_pkg::STRETCH_CYCLES,
    parameter int P_BLINK_CYCLES = pcr_pkg::BLINK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    input wire logic i_strap_auto_crossover,
    input wire logic i_strap_indicator_mode,
    input wire logic [4:0] i_strap_port_address,
    input wire pcr_pkg::pcr_neg_s i_neg,
    input wire logic i_selftest_nibble_error,
    input wire logic i_link_good,
    input wire logic i_speed_100,
    input wire logic i_activity,
    output logic o_auto_crossover_enable,
    output logic o_force_crossover,
    output logic o_pause_rx,
    output logic o_pause_tx,
    output logic o_selftest_run,
    output logic o_selftest_sequence_select,
    output logic o_selftest_error_inject,
    output logic [4:0] o_port_management_address,
    output logic o_link_indicator,
    output logic o_speed_indicator
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // Indicator stretchers
    // ------------------------------------------------------------
    logic act_str;
    logic speed_str;
    logic link_str;
    pcr_pkg::pcr_state_s st_reg;
    pcr_pkg::pcr_state_s st_next;

    pcr_stretch #(.P_CYCLES(P_STRETCH_CYCLES)) u_act (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_raw(i_activity),
        .i_bypass(st_reg.indicator_stretch_bypass),
        .o_out(act_str)
    );
    pcr_stretch #(.P_CYCLES(P_STRETCH_CYCLES)) u_speed (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_raw(i_speed_100),
        .i_bypass(st_reg.indicator_stretch_bypass),
        .o_out(speed_str)
    );
    pcr_stretch #(.P_CYCLES(P_STRETCH_CYCLES)) u_link (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_raw(i_link_good),
        .i_bypass(st_reg.indicator_stretch_bypass),
        .o_out(link_str)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic wr_ctl;
    logic rd_ctl;
    logic rd_ext;
    logic both_pause;
    logic res_tx;
    logic res_rx;
    logic pass_flag;
    logic [15:0] ctl_view;

    always_comb begin
        wr_ctl = i_reg_wr && (i_reg_addr == pcr_pkg::PHY_CONTROL_OFS);
        rd_ctl = i_reg_rd && (i_reg_addr == pcr_pkg::PHY_CONTROL_OFS);
        rd_ext = i_reg_rd && (i_reg_addr == pcr_pkg::SELFTEST_EXTENSION_OFS);

        // Symmetric and asymmetric pause resolution
        both_pause = i_neg.local_advertisement[0] & i_neg.partner_ability[0];
        res_tx = both_pause | (~i_neg.local_advertisement[0] & i_neg.local_advertisement[1]
            & i_neg.partner_ability[0] & i_neg.partner_ability[1]);
        res_rx = both_pause | (i_neg.local_advertisement[0] & i_neg.local_advertisement[1]
            & ~i_neg.partner_ability[0] & i_neg.partner_ability[1]);

        pass_flag = st_reg.selftest_run & ~st_reg.fail_latched;

        ctl_view = '0;
        ctl_view[pcr_pkg::AUTO_XOVER_BIT] = st_reg.auto_crossover_enable;
        ctl_view[pcr_pkg::FORCE_XOVER_BIT] = st_reg.force_crossover;
        ctl_view[pcr_pkg::PAUSE_RX_BIT] = st_reg.pause_rx;
        ctl_view[pcr_pkg::PAUSE_TX_BIT] = st_reg.pause_tx;
        ctl_view[pcr_pkg::ERR_INJECT_BIT] = st_reg.selftest_error_inject;
        ctl_view[pcr_pkg::SEQ_SELECT_BIT] = st_reg.selftest_sequence_select;
        ctl_view[pcr_pkg::PASS_FLAG_BIT] = pass_flag;
        ctl_view[pcr_pkg::RUN_BIT] = st_reg.selftest_run;
        ctl_view[pcr_pkg::STRETCH_BYPASS_BIT] = st_reg.indicator_stretch_bypass;
        ctl_view[pcr_pkg::MODE_SELECT_BIT] = st_reg.indicator_mode_select;
        ctl_view[pcr_pkg::ADDR_LSB +: pcr_pkg::ADDR_W] = st_reg.port_management_address;

        st_next = st_reg;
        st_next.selftest_error_inject = 1'b0;

        // Straps load once after reset release
        if (!st_reg.strap_done) begin
            st_next.strap_done = 1'b1;
            st_next.auto_crossover_enable = i_strap_auto_crossover;
            st_next.indicator_mode_select = i_strap_indicator_mode;
            st_next.port_management_address = i_strap_port_address;
        end else if (wr_ctl) begin
            st_next.auto_crossover_enable = i_reg_wdata[pcr_pkg::AUTO_XOVER_BIT];
            st_next.force_crossover = i_reg_wdata[pcr_pkg::FORCE_XOVER_BIT];
            st_next.selftest_error_inject = i_reg_wdata[pcr_pkg::ERR_INJECT_BIT];
            st_next.selftest_sequence_select = i_reg_wdata[pcr_pkg::SEQ_SELECT_BIT];
            st_next.selftest_run = i_reg_wdata[pcr_pkg::RUN_BIT];
            st_next.indicator_stretch_bypass = i_reg_wdata[pcr_pkg::STRETCH_BYPASS_BIT];
            st_next.indicator_mode_select = i_reg_wdata[pcr_pkg::MODE_SELECT_BIT];
            st_next.port_management_address =
                i_reg_wdata[pcr_pkg::ADDR_LSB +: pcr_pkg::ADDR_W];
        end

        st_next.pause_rx = res_rx & i_neg.full_duplex;
        st_next.pause_tx = res_tx & i_neg.full_duplex;

        // Error counting while running, restart clears
        if (!st_reg.selftest_run && st_next.selftest_run) begin
            st_next.selftest_error_counter = '0;
            st_next.fail_latched = 1'b0;
        end else if (st_reg.selftest_run && i_selftest_nibble_error) begin
            st_next.fail_latched = 1'b1;
            if (st_reg.selftest_error_counter != pcr_pkg::ERR_CNT_MAX) begin
                st_next.selftest_error_counter = st_reg.selftest_error_counter + 1'b1;
            end
        end
        if (!st_next.selftest_run) begin
            st_next.fail_latched = 1'b0;
        end

        if (rd_ctl) begin
            st_next.rdata = ctl_view;
        end else if (rd_ext) begin
            st_next.rdata = {st_reg.selftest_error_counter, 8'h00};
        end else if (i_reg_rd) begin
            st_next.rdata = '0;
        end

        // Blink timing for activity
        if (st_reg.blink_timer == '0) begin
            st_next.blink_timer = pcr_pkg::TIMER_W'(P_BLINK_CYCLES - 1);
            st_next.blink_phase = ~st_reg.blink_phase;
        end else begin
            st_next.blink_timer = st_reg.blink_timer - 1'b1;
        end

        if (st_reg.indicator_mode_select) begin
            st_next.link_indicator = link_str;
        end else begin
            st_next.link_indicator = link_str & ~(act_str & st_reg.blink_phase);
        end
        st_next.speed_indicator = speed_str;
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_reg_rdata = st_reg.rdata;
    assign o_auto_crossover_enable = st_reg.auto_crossover_enable;
    assign o_force_crossover = st_reg.force_crossover;
    assign o_pause_rx = st_reg.pause_rx;
    assign o_pause_tx = st_reg.pause_tx;
    assign o_selftest_run = st_reg.selftest_run;
    assign o_selftest_sequence_select = st_reg.selftest_sequence_select;
    assign o_selftest_error_inject = st_reg.selftest_error_inject;
    assign o_port_management_address = st_reg.port_management_address;
    assign o_link_indicator = st_reg.link_indicator;
    assign o_speed_indicator = st_reg.speed_indicator;
endmodule

// [pcr_phy_control_bench.sv]
// Self-checking bench for the PHY control register
`timescale 1ns/1ps
module pcr_phy_control_bench;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [4:0] i_reg_addr = 5'h00, i_strap_port_address = 5'h00, o_port_management_address;
    logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
    logic i_strap_auto_crossover = 1'b0, i_strap_indicator_mode = 1'b0;
    logic i_selftest_nibble_error = 1'b0, i_link_good = 1'b0, i_speed_100 = 1'b0;
    logic i_activity = 1'b0;
    pcr_pkg::pcr_neg_s i_neg = 5'h00;
    logic o_auto_crossover_enable, o_force_crossover, o_pause_rx, o_pause_tx;
    logic o_selftest_run, o_selftest_sequence_select, o_selftest_error_inject;
    logic o_link_indicator, o_speed_indicator;
    int n_mismatch = 0, compares = 0, n_inj = 0;
    pcr_phy_control #(.P_STRETCH_CYCLES(8), .P_BLINK_CYCLES(8)) dut (.i_mclk, .i_rst_n,
        .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_strap_auto_crossover,
        .i_strap_indicator_mode, .i_strap_port_address, .i_neg, .i_selftest_nibble_error,
        .i_link_good, .i_speed_100, .i_activity, .o_auto_crossover_enable, .o_force_crossover,
        .o_pause_rx, .o_pause_tx, .o_selftest_run, .o_selftest_sequence_select,
        .o_selftest_error_inject, .o_port_management_address, .o_link_indicator,
        .o_speed_indicator);
    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end
    always @(negedge i_mclk) begin
        if (o_selftest_error_inject === 1'b1) n_inj++;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        idle(1);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        idle(1);
        i_reg_rd = 1'b0;
        idle(1);
        chk(o_reg_rdata, exp);
    endtask
    task automatic err(input int n);
        repeat (n) begin
            idle(1);
            i_selftest_nibble_error = 1'b1;
            idle(1);
            i_selftest_nibble_error = 1'b0;
        end
    endtask
    task automatic watch(input int n, output int off);
        off = 0;
        repeat (n) begin
            idle(1);
            if (o_link_indicator !== 1'b1) off++;
        end
    endtask
    task automatic summarize;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_strap(input logic x, input logic m, input logic [4:0] a,
        input logic [15:0] exp);
        i_strap_auto_crossover = x;
        i_strap_indicator_mode = m;
        i_strap_port_address = a;
        i_rst_n = 1'b0;
        idle(20);
        i_rst_n = 1'b1;
        idle(6);
        rd(5'h19, exp);
        chk(16'(o_port_management_address), 16'(exp[4:0]));
        chk(16'(o_auto_crossover_enable), 16'(exp[15]));
    endtask
    task automatic t_selftest;
        int n;
        n = n_inj;
        wr(5'h19, 16'hffbf);
        rd(5'h19, 16'hc7bf);
        chk({14'h0000, o_selftest_run, o_selftest_sequence_select}, 16'h0003);
        chk(16'(n_inj - n), 16'h0001);
        err(3);
        rd(5'h19, 16'hc5bf);
        rd(5'h1b, 16'h0300);
        wr(5'h19, 16'h0000);
        rd(5'h19, 16'h0000);
        chk(16'(n_inj - n), 16'h0001);
        wr(5'h19, 16'h0100);
        rd(5'h1b, 16'h0000);
        rd(5'h19, 16'h0300);
        err(260);
        rd(5'h1b, 16'hff00);
    endtask
    task automatic t_refuse;
        wr(5'h19, 16'h3200);
        rd(5'h19, 16'h0000);
        wr(5'h19, 16'h8421);
        wr(5'h1b, 16'hffff);
        wr(5'h1a, 16'hffff);
        rd(5'h19, 16'h8421);
        rd(5'h1b, 16'hff00);
        rd(5'h1a, 16'h0000);
    endtask
    task automatic t_pause;
        logic [1:0] l, p;
        logic [15:0] e;
        for (int i = 0; i < 32; i++) begin
            i_neg = pcr_pkg::pcr_neg_s'(i[4:0]);
            l = i[4:3];
            p = i[2:1];
            e = 16'h8421;
            e[13] = i[0] && ((l[0] && p[0]) || (l == 2'h3 && p == 2'h2));
            e[12] = i[0] && ((l[0] && p[0]) || (l == 2'h2 && p == 2'h3));
            rd(5'h19, e);
            chk({14'h0000, o_pause_rx, o_pause_tx}, {14'h0000, e[13:12]});
        end
        i_neg = 5'h00;
    endtask
    task automatic t_led;
        int off;
        i_link_good = 1'b1;
        i_speed_100 = 1'b1;
        i_activity = 1'b1;
        wr(5'h19, 16'h00a0);
        watch(30, off);
        chk(16'(off), 16'h0000);
        chk({15'h0000, o_speed_indicator}, 16'h0001);
        wr(5'h19, 16'h0080);
        watch(30, off);
        chk({15'h0000, off > 0}, 16'h0001);
        chk({15'h0000, o_speed_indicator}, 16'h0001);
        i_activity = 1'b0;
        i_speed_100 = 1'b0;
        idle(4);
        watch(30, off);
        chk(16'(off), 16'h0000);
        chk({15'h0000, o_speed_indicator}, 16'h0000);
        i_link_good = 1'b0;
        idle(4);
        chk({15'h0000, o_link_indicator}, 16'h0000);
        wr(5'h19, 16'h0020);
        i_link_good = 1'b1;
        idle(2);
        i_link_good = 1'b0;
        idle(4);
        chk({15'h0000, o_link_indicator}, 16'h0001);
        idle(8);
        chk({15'h0000, o_link_indicator}, 16'h0000);
    endtask
    initial begin
        t_strap(1'b1, 1'b0, 5'h15, 16'h8015);
        t_selftest();
        t_refuse();
        t_pause();
        t_led();
        t_strap(1'b0, 1'b1, 5'h0a, 16'h002a);
        summarize();
    end
    initial begin
        #(25 * 20000);
        n_mismatch++;
        summarize();
    end
endmodule

// [pcr_phy_control_checker.sv]
// Port checker for the PHY control register
`timescale 1ns/1ps
module pcr_phy_control_checker (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] o_reg_rdata,
    input wire pcr_pkg::pcr_neg_s i_neg,
    input wire logic o_auto_crossover_enable,
    input wire logic o_force_crossover,
    input wire logic o_pause_rx,
    input wire logic o_pause_tx,
    input wire logic o_selftest_run,
    input wire logic o_selftest_sequence_select,
    input wire logic o_selftest_error_inject,
    input wire logic [4:0] o_port_management_address
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [2:0] up_reg;
    logic live, wr19, rd19, rx_e, tx_e;
    logic [1:0] l, p;
    logic [8:0] ctl;
    assign live = up_reg == 3'h5;
    assign wr19 = live && i_reg_wr && i_reg_addr == pcr_pkg::PHY_CONTROL_OFS;
    assign rd19 = live && i_reg_rd && i_reg_addr == pcr_pkg::PHY_CONTROL_OFS;
    assign l = i_neg.local_advertisement;
    assign p = i_neg.partner_ability;
    assign rx_e = i_neg.full_duplex && ((l[0] && p[0]) || (l == 2'h3 && p == 2'h2));
    assign tx_e = i_neg.full_duplex && ((l[0] && p[0]) || (l == 2'h2 && p == 2'h3));
    assign ctl = {o_auto_crossover_enable, o_force_crossover, o_selftest_sequence_select,
        o_selftest_run, o_port_management_address};
    // Counts edges after reset so straps have landed
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_reg <= 3'h0;
        end else if (up_reg != 3'h5) begin
            up_reg <= up_reg + 3'h1;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_pulse;
        o_selftest_error_inject ##1 !o_selftest_error_inject;
    endsequence
    property p_inject;
        wr19 && i_reg_wdata[11] |=> s_pulse;
    endproperty
    a_inject: assert property (p_inject) else $error("inject pulse wrong");
    property p_inject_cause;
        $rose(o_selftest_error_inject) |-> $past(wr19 && i_reg_wdata[11]);
    endproperty
    a_inject_cause: assert property (p_inject_cause) else $error("stray inject");
    property p_write;
        wr19 |=> ctl == $past({i_reg_wdata[15:14], i_reg_wdata[10], i_reg_wdata[8],
            i_reg_wdata[4:0]});
    endproperty
    a_write: assert property (p_write) else $error("write not applied");
    property p_hold;
        live && !wr19 |=> $stable(ctl);
    endproperty
    a_hold: assert property (p_hold) else $error("control changed");
    property p_pause;
        live |=> o_pause_rx == $past(rx_e) && o_pause_tx == $past(tx_e);
    endproperty
    a_pause: assert property (p_pause) else $error("pause wrong");
    property p_rsvd;
        rd19 |=> !o_reg_rdata[6];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_selfclr;
        rd19 && !o_selftest_error_inject |=> !o_reg_rdata[11];
    endproperty
    a_selfclr: assert property (p_selfclr) else $error("inject bit stuck");
    property p_readback;
        rd19 && !i_reg_wr |=> o_reg_rdata[15:12] == $past({o_auto_crossover_enable,
            o_force_crossover, o_pause_rx, o_pause_tx})
            && o_reg_rdata[4:0] == $past(o_port_management_address);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");
endmodule
bind pcr_phy_control pcr_phy_control_checker u_chk (.i_mclk, .i_rst_n, .i_reg_addr,
    .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_neg, .o_auto_crossover_enable,
    .o_force_crossover, .o_pause_rx, .o_pause_tx, .o_selftest_run,
    .o_selftest_sequence_select, .o_selftest_error_inject, .o_port_management_address);

// [pcr_pkg.sv]
// Shared constants and types for the PHY control register block
package pcr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] PHY_CONTROL_OFS = 5'h19;
    localparam logic [4:0] SELFTEST_EXTENSION_OFS = 5'h1b;

    // ------------------------------------------------------------
    // Field positions of phy_control
    // ------------------------------------------------------------
    localparam int AUTO_XOVER_BIT = 15;
    localparam int FORCE_XOVER_BIT = 14;
    localparam int PAUSE_RX_BIT = 13;
    localparam int PAUSE_TX_BIT = 12;
    localparam int ERR_INJECT_BIT = 11;
    localparam int SEQ_SELECT_BIT = 10;
    localparam int PASS_FLAG_BIT = 9;
    localparam int RUN_BIT = 8;
    localparam int STRETCH_BYPASS_BIT = 7;
    localparam int RESERVED_BIT = 6;
    localparam int MODE_SELECT_BIT = 5;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 5;
    localparam int ERR_CNT_LSB = 8;
    localparam int ERR_CNT_W = 8;

    // ------------------------------------------------------------
    // Reset and saturation values
    // ------------------------------------------------------------
    localparam logic [15:0] RDATA_RST = 16'h0000;
    localparam logic [ERR_CNT_W-1:0] ERR_CNT_MAX = 8'hff;

    // ------------------------------------------------------------
    // Timing of the indicators
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 40000;
    localparam int STRETCH_TIME_MS = 50;
    localparam int BLINK_TIME_MS = 50;
    localparam int STRETCH_CYCLES = STRETCH_TIME_MS * CLK_FREQ_KHZ;
    localparam int BLINK_CYCLES = BLINK_TIME_MS * CLK_FREQ_KHZ;
    localparam int TIMER_W = 24;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic strap_done;
        logic auto_crossover_enable;
        logic force_crossover;
        logic pause_rx;
        logic pause_tx;
        logic selftest_error_inject;
        logic selftest_sequence_select;
        logic fail_latched;
        logic selftest_run;
        logic indicator_stretch_bypass;
        logic indicator_mode_select;
        logic [ADDR_W-1:0] port_management_address;
        logic [ERR_CNT_W-1:0] selftest_error_counter;
        logic [15:0] rdata;
        logic [TIMER_W-1:0] blink_timer;
        logic blink_phase;
        logic link_indicator;
        logic speed_indicator;
    } pcr_state_s;

    typedef struct packed {
        logic [TIMER_W-1:0] count;
        logic out;
    } pcr_stretch_s;

    typedef struct packed {
        logic [1:0] local_advertisement;
        logic [1:0] partner_ability;
        logic full_duplex;
    } pcr_neg_s;

endpackage

// [pcr_stretch.sv]
// Pulse stretcher for one indicator with bypass
`timescale 1ns/1ps
module pcr_stretch #(
    parameter int P_CYCLES = pcr_pkg::STRETCH_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_raw,
    input wire logic i_bypass,
    output logic o_out
);
    pcr_pkg::pcr_stretch_s st_reg;
    pcr_pkg::pcr_stretch_s st_next;

    always_comb begin
        st_next = st_reg;
        if (i_raw) begin
            st_next.count = pcr_pkg::TIMER_W'(P_CYCLES - 1);
        end else if (st_reg.count != '0) begin
            st_next.count = st_reg.count - 1'b1;
        end
        // Bypass passes the raw level through
        st_next.out = i_bypass ? i_raw : (i_raw | (st_reg.count != '0));
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_out = st_reg.out;
endmodule
